// ===== include/uart_irq_format_defs.vh
/*
  Constants for the UART interrupt identification and line format block:
  register byte offsets, field positions, reset values and source codes.
  Assumes inclusion by bare name from a design file on a 32-bit AXI4-Lite bus.
*/
`ifndef UART_IRQ_FORMAT_DEFS_VH
`define UART_IRQ_FORMAT_DEFS_VH

// Register byte offsets
`define OFS_IDENT 8'h00
`define OFS_LINE_FMT 8'h04
`define OFS_IRQ_ENABLE 8'h08
`define OFS_FEATURE 8'h0C
`define OFS_FIFO_SETUP 8'h10
`define OFS_DIVISOR 8'h14

// Reset values
`define RST_LINE_FMT 8'h00
`define RST_IRQ_ENABLE 8'h00
`define RST_FEATURE 8'h00
`define RST_FIFO_SETUP 8'h00
`define RST_DIVISOR 16'h0001
`define RST_IDENT 8'h01

// Line format fields
`define LF_DLAB 7
`define LF_BREAK 6
`define LF_PAR_HI 5
`define LF_PAR_LO 3
`define LF_STOP 2
`define LF_WLEN_HI 1
`define LF_WLEN_LO 0

// Parity selections (bits 5..3)
`define PAR_ODD 3'h1
`define PAR_EVEN 3'h3
`define PAR_FORCE1 3'h5
`define PAR_FORCE0 3'h7

// Parity mode output encoding
`define PMODE_ODD 2'h0
`define PMODE_EVEN 2'h1
`define PMODE_FORCE1 2'h2
`define PMODE_FORCE0 2'h3

// Interrupt enable fields
`define IE_RX_DATA 0
`define IE_TX_EMPTY 1
`define IE_LINE_STAT 2
`define IE_MODEM 3
`define IE_XOFF 4
`define IE_CTS_RTS 5

// Enhanced feature enable and FIFO setup fields
`define FEAT_ENH 4
`define FS_ENABLE 0
`define FS_RX_RESET 1
`define FS_TX_RESET 2
`define FS_WR_MASK 8'hC8

// Identification codes, bits 5..0 with bit 0 the not-pending flag
`define ID_LINE_STAT 6'h06
`define ID_RX_DATA 6'h04
`define ID_RX_TIMEOUT 6'h0C
`define ID_TX_EMPTY 6'h02
`define ID_MODEM 6'h00
`define ID_XOFF 6'h10
`define ID_CTS_RTS 6'h20
`define ID_NONE 6'h01

// AXI responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// ===== logic/uart_irq_format.v
/*
  UART interrupt identification and line format control with an AXI4-Lite
  register slave. Assumes the receiver, transmitter, FIFOs and flow control
  sit elsewhere on the same clock and present their conditions as levels
  or one-cycle pulses; those conditions clear by their own service action.
*/
// The address map and the AXI4-Lite register port are this design's own decisions.
`timescale 1ns/1ps
`include "uart_irq_format_defs.vh"

// Notes on behaviour
// - Identification returns highest pending priority code
// - Current source reported until it is serviced
// - Line status is level 1, code 000110
// - Data available is level 2, code 000100
// - Receive timeout is level 2, code 001100
// - Transmit holding empty is level 3, 000010
// - Modem status is level 4, code 000000
// - Xoff or special character level 5, 010000
// - CTS or RTS change level 6, 100000
// - Bits 5 and 4 need enhanced enable
// - Xoff flag holds until Xon received
// - Bits 7 and 6 show FIFO enable
// - Bit 0 low means interrupt pending
// - Format bit 7 opens divisor and features
// - Format bit 6 forces transmit line low
// - Bits 5..3 select parity mode
// - Bit 2 selects stop bit length
// - Bits 1..0 select word length
// - FIFO enable gates other setup bits
module uart_irq_format (
  input wire clk_in,
  input wire reset_n_in,
  input wire [7:0] s_axi_awaddr_in,
  input wire s_axi_awvalid_in,
  output reg s_axi_awready_out,
  input wire [31:0] s_axi_wdata_in,
  input wire [3:0] s_axi_wstrb_in,
  input wire s_axi_wvalid_in,
  output reg s_axi_wready_out,
  output reg [1:0] s_axi_bresp_out,
  output reg s_axi_bvalid_out,
  input wire s_axi_bready_in,
  input wire [7:0] s_axi_araddr_in,
  input wire s_axi_arvalid_in,
  output reg s_axi_arready_out,
  output reg [31:0] s_axi_rdata_out,
  output reg [1:0] s_axi_rresp_out,
  output reg s_axi_rvalid_out,
  input wire s_axi_rready_in,
  input wire line_status_in,
  input wire rx_data_avail_in,
  input wire rx_timeout_in,
  input wire tx_holding_empty_in,
  input wire modem_status_in,
  input wire xoff_match_in,
  input wire xon_match_in,
  input wire cts_rts_change_in,
  input wire tx_serial_in,
  output reg tx_line_out,
  output reg irq_pending_out,
  output reg [1:0] word_len_out,
  output reg long_stop_out,
  output reg parity_enable_out,
  output reg [1:0] parity_mode_out,
  output reg fifo_enable_out,
  output reg rx_fifo_reset_out,
  output reg tx_fifo_reset_out,
  output reg [15:0] divisor_out
);

  reg [7:0] line_fmt_r;
  reg [7:0] irq_enable_r;
  reg [7:0] feature_r;
  reg [7:0] fifo_setup_r;
  reg [15:0] divisor_r;
  reg [7:0] ident_r;
  reg [7:0] ident_nxt;
  reg xoff_flag_r;
  reg cts_rts_flag_r;

  reg aw_full_r;
  reg aw_full_nxt;
  reg [7:0] aw_addr_r;
  reg w_full_r;
  reg w_full_nxt;
  reg [31:0] w_data_r;
  reg [3:0] w_strb_r;
  reg bvalid_nxt;
  reg rvalid_nxt;
  reg [31:0] rd_data;
  reg [1:0] rd_resp;
  reg wr_err;

  wire aw_take = s_axi_awvalid_in & s_axi_awready_out;
  wire w_take = s_axi_wvalid_in & s_axi_wready_out;
  wire wr_go = aw_full_r & w_full_r & ~s_axi_bvalid_out;
  wire ar_take = s_axi_arvalid_in & s_axi_arready_out;
  wire dlab = line_fmt_r[`LF_DLAB];
  wire enh = feature_r[`FEAT_ENH];
  wire wr_lane0 = w_strb_r[0];
  wire wr_lane1 = w_strb_r[1];
  wire [2:0] par_sel = line_fmt_r[`LF_PAR_HI:`LF_PAR_LO];
  // The identification code is read once it is stable; a reported
  // CTS/RTS change is cleared by that read.
  wire ident_read = ar_take & (s_axi_araddr_in == `OFS_IDENT);
  wire cts_rts_reported = (ident_r[5:0] == `ID_CTS_RTS);

  wire src_line = line_status_in & irq_enable_r[`IE_LINE_STAT];
  wire src_rx = rx_data_avail_in & irq_enable_r[`IE_RX_DATA];
  wire src_tmo = rx_timeout_in & irq_enable_r[`IE_RX_DATA];
  wire src_tx = tx_holding_empty_in & irq_enable_r[`IE_TX_EMPTY];
  wire src_modem = modem_status_in & irq_enable_r[`IE_MODEM];
  wire src_xoff = xoff_flag_r & irq_enable_r[`IE_XOFF] & enh;
  wire src_cts = cts_rts_flag_r & irq_enable_r[`IE_CTS_RTS] & enh;

  // the source stays until its condition is serviced
  always @*
  begin
    ident_nxt[7:6] = fifo_setup_r[`FS_ENABLE] ? 2'h3 : 2'h0;
    if (src_line)
      ident_nxt[5:0] = `ID_LINE_STAT;
    else if (src_tmo)
      ident_nxt[5:0] = `ID_RX_TIMEOUT;
    else if (src_rx)
      ident_nxt[5:0] = `ID_RX_DATA;
    else if (src_tx)
      ident_nxt[5:0] = `ID_TX_EMPTY;
    else if (src_modem)
      ident_nxt[5:0] = `ID_MODEM;
    else if (src_xoff)
      ident_nxt[5:0] = `ID_XOFF;
    else if (src_cts)
      ident_nxt[5:0] = `ID_CTS_RTS;
    else
      ident_nxt[5:0] = `ID_NONE;
  end

  always @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      ident_r <= `RST_IDENT;
      irq_pending_out <= 1'b0;
      xoff_flag_r <= 1'b0;
      cts_rts_flag_r <= 1'b0;
    end
    else
    begin
      ident_r <= ident_nxt;
      irq_pending_out <= ~ident_nxt[0];
      if (xoff_match_in)
        xoff_flag_r <= 1'b1;
      else if (xon_match_in)
        xoff_flag_r <= 1'b0;
      if (cts_rts_change_in)
        cts_rts_flag_r <= 1'b1;
      else if (ident_read & cts_rts_reported)
        cts_rts_flag_r <= 1'b0;
    end
  end

  // Write channel bookkeeping; address and data may arrive in either order
  // A commit empties both holding slots; readies stay low while they are full
  always @*
  begin
    aw_full_nxt = (aw_full_r | aw_take) & ~wr_go;
    w_full_nxt = (w_full_r | w_take) & ~wr_go;
    bvalid_nxt = wr_go | (s_axi_bvalid_out & ~s_axi_bready_in);
  end

  // divisor and feature offsets exist only with the latch bit set
  always @*
  begin
    case (aw_addr_r)
      `OFS_IDENT, `OFS_LINE_FMT, `OFS_IRQ_ENABLE, `OFS_FIFO_SETUP:
        wr_err = 1'b0;
      `OFS_FEATURE, `OFS_DIVISOR:
        wr_err = ~dlab;
      default:
        wr_err = 1'b1;
    endcase
  end

  always @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      aw_full_r <= 1'b0;
      w_full_r <= 1'b0;
      aw_addr_r <= 8'h00;
      w_data_r <= 32'h00000000;
      w_strb_r <= 4'h0;
      s_axi_awready_out <= 1'b0;
      s_axi_wready_out <= 1'b0;
      s_axi_bvalid_out <= 1'b0;
      s_axi_bresp_out <= `RESP_OKAY;
      line_fmt_r <= `RST_LINE_FMT;
      irq_enable_r <= `RST_IRQ_ENABLE;
      feature_r <= `RST_FEATURE;
      fifo_setup_r <= `RST_FIFO_SETUP;
      divisor_r <= `RST_DIVISOR;
      rx_fifo_reset_out <= 1'b0;
      tx_fifo_reset_out <= 1'b0;
    end
    else
    begin
      aw_full_r <= aw_full_nxt;
      w_full_r <= w_full_nxt;
      s_axi_bvalid_out <= bvalid_nxt;
      s_axi_awready_out <= ~aw_full_nxt & ~bvalid_nxt;
      s_axi_wready_out <= ~w_full_nxt & ~bvalid_nxt;
      rx_fifo_reset_out <= 1'b0;
      tx_fifo_reset_out <= 1'b0;
      if (aw_take)
        aw_addr_r <= s_axi_awaddr_in;
      if (w_take)
      begin
        w_data_r <= s_axi_wdata_in;
        w_strb_r <= s_axi_wstrb_in;
      end
      if (wr_go)
      begin
        s_axi_bresp_out <= wr_err ? `RESP_SLVERR : `RESP_OKAY;
        if (!wr_err && wr_lane0)
          case (aw_addr_r)
            `OFS_LINE_FMT:
              line_fmt_r <= w_data_r[7:0];
            `OFS_IRQ_ENABLE:
              irq_enable_r <= {2'h0, w_data_r[5:0]};
            `OFS_FEATURE:
              feature_r <= w_data_r[7:0];
            `OFS_FIFO_SETUP:
            begin
              // other setup bits only with enable written as one
              fifo_setup_r[`FS_ENABLE] <= w_data_r[`FS_ENABLE];
              if (w_data_r[`FS_ENABLE])
              begin
                fifo_setup_r <= (w_data_r[7:0] & `FS_WR_MASK) | 8'h01;
                rx_fifo_reset_out <= w_data_r[`FS_RX_RESET];
                tx_fifo_reset_out <= w_data_r[`FS_TX_RESET];
              end
            end
            `OFS_DIVISOR:
              divisor_r[7:0] <= w_data_r[7:0];
            default:
              divisor_r <= divisor_r;
          endcase
        if (!wr_err && wr_lane1 && (aw_addr_r == `OFS_DIVISOR))
          divisor_r[15:8] <= w_data_r[15:8];
      end
    end
  end

  // Read data mux; reserved bits read as zero
  always @*
  begin
    rd_data = 32'h00000000;
    rd_resp = `RESP_OKAY;
    case (s_axi_araddr_in)
      `OFS_IDENT:
        rd_data[7:0] = ident_r;
      `OFS_LINE_FMT:
        rd_data[7:0] = line_fmt_r;
      `OFS_IRQ_ENABLE:
        rd_data[7:0] = irq_enable_r;
      `OFS_FIFO_SETUP:
        rd_data[7:0] = fifo_setup_r;
      `OFS_FEATURE:
        if (dlab)
          rd_data[7:0] = feature_r;
        else
          rd_resp = `RESP_SLVERR;
      `OFS_DIVISOR:
        if (dlab)
          rd_data[15:0] = divisor_r;
        else
          rd_resp = `RESP_SLVERR;
      default:
        rd_resp = `RESP_SLVERR;
    endcase
  end

  always @*
  begin
    rvalid_nxt = ar_take | (s_axi_rvalid_out & ~s_axi_rready_in);
  end

  always @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      s_axi_arready_out <= 1'b0;
      s_axi_rvalid_out <= 1'b0;
      s_axi_rdata_out <= 32'h00000000;
      s_axi_rresp_out <= `RESP_OKAY;
    end
    else
    begin
      s_axi_rvalid_out <= rvalid_nxt;
      s_axi_arready_out <= ~rvalid_nxt;
      if (ar_take)
      begin
        s_axi_rdata_out <= rd_data;
        s_axi_rresp_out <= rd_resp;
      end
    end
  end

  // Format outputs registered so the line side sees stable values
  always @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      tx_line_out <= 1'b1;
      word_len_out <= 2'h0;
      long_stop_out <= 1'b0;
      parity_enable_out <= 1'b0;
      parity_mode_out <= `PMODE_ODD;
      fifo_enable_out <= 1'b0;
      divisor_out <= `RST_DIVISOR;
    end
    else
    begin
      tx_line_out <= tx_serial_in & ~line_fmt_r[`LF_BREAK];
      word_len_out <= line_fmt_r[`LF_WLEN_HI:`LF_WLEN_LO];
      // 1.5 or 2 stop bits by word length
      long_stop_out <= line_fmt_r[`LF_STOP];
      parity_enable_out <= par_sel[0];
      case (par_sel)
        `PAR_EVEN:
          parity_mode_out <= `PMODE_EVEN;
        `PAR_FORCE1:
          parity_mode_out <= `PMODE_FORCE1;
        `PAR_FORCE0:
          parity_mode_out <= `PMODE_FORCE0;
        default:
          parity_mode_out <= `PMODE_ODD;
      endcase
      fifo_enable_out <= fifo_setup_r[`FS_ENABLE];
      divisor_out <= divisor_r;
    end
  end

endmodule

// ===== testbench/axi_host_model.sv
/*
  AXI4-Lite host model issuing one register access at a time.
  Assumes the slave holds its answer until the host accepts it.
*/
`timescale 1ns/1ps
module axi_host_model (
  input wire clk_in,
  output reg [7:0] awaddr_out,
  output reg awvalid_out,
  input wire awready_in,
  output reg [31:0] wdata_out,
  output reg [3:0] wstrb_out,
  output reg wvalid_out,
  input wire wready_in,
  input wire [1:0] bresp_in,
  input wire bvalid_in,
  output reg bready_out,
  output reg [7:0] araddr_out,
  output reg arvalid_out,
  input wire arready_in,
  input wire [31:0] rdata_in,
  input wire [1:0] rresp_in,
  input wire rvalid_in,
  output reg rready_out
);
  initial
  begin
    {awaddr_out, awvalid_out, wdata_out, wvalid_out, bready_out} = 43'h0;
    {araddr_out, arvalid_out, rready_out} = 10'h000;
    wstrb_out = 4'hF;
  end
  task wr(input [7:0] a, input [31:0] d, output [1:0] resp);
    begin
      @(posedge clk_in);
      awaddr_out <= a;
      wdata_out <= d;
      awvalid_out <= 1'b1;
      wvalid_out <= 1'b1;
      bready_out <= 1'b1;
      do
      begin
        @(posedge clk_in);
        if (awready_in) awvalid_out <= 1'b0;
        if (wready_in) wvalid_out <= 1'b0;
      end while (!bvalid_in);
      resp = bresp_in;
      bready_out <= 1'b0;
    end
  endtask
  task rd(input [7:0] a, output [31:0] d, output [1:0] resp);
    begin
      @(posedge clk_in);
      araddr_out <= a;
      arvalid_out <= 1'b1;
      rready_out <= 1'b1;
      do
      begin
        @(posedge clk_in);
        if (arready_in) arvalid_out <= 1'b0;
      end while (!rvalid_in);
      d = rdata_in;
      resp = rresp_in;
      rready_out <= 1'b0;
    end
  endtask
endmodule

// ===== testbench/testbench.sv
/*
  Self-checking bench for the UART interrupt and line format block.
  Assumes the host model and the bound checker are compiled before it.
*/
`timescale 1ns/1ps
module testbench;
  reg clk_in, reset_n_in, xoff, xon, cts, txs;
  reg [4:0] lv;
  reg [31:0] rd_d;
  reg [1:0] rs;
  reg [7:0] v;
  wire [7:0] awaddr, araddr;
  wire [31:0] wdata, rdata;
  wire [3:0] wstrb;
  wire [1:0] bresp, rresp, wlen, pmode;
  wire awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  wire tx_line, irq, lstop, pen, fen;
  wire rx_rst, tx_rst;
  reg [1:0] fr_seen = 2'h0;
  wire [15:0] div;
  integer n_fail, n_compared, k;
  // Expected identification codes as sources drop one by one
  localparam [47:0] ID_SEQ = {8'h06, 8'h0C, 8'h04, 8'h02, 8'h00, 8'h10};

  always #2 clk_in = ~clk_in;
  // FIFO reset pulses last one cycle; latch them so a scenario can look later
  always @(posedge clk_in) fr_seen <= fr_seen | {tx_rst, rx_rst};

  uart_irq_format u_uart_irq_format (.clk_in(clk_in), .reset_n_in(reset_n_in),
    .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
    .s_axi_wdata_in(wdata), .s_axi_wstrb_in(wstrb), .s_axi_wvalid_in(wvalid),
    .s_axi_wready_out(wready), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid),
    .s_axi_bready_in(bready), .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
    .s_axi_arready_out(arready), .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp),
    .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready), .line_status_in(lv[0]),
    .rx_timeout_in(lv[1]), .rx_data_avail_in(lv[2]), .tx_holding_empty_in(lv[3]),
    .modem_status_in(lv[4]), .xoff_match_in(xoff), .xon_match_in(xon),
    .cts_rts_change_in(cts), .tx_serial_in(txs), .tx_line_out(tx_line),
    .irq_pending_out(irq), .word_len_out(wlen), .long_stop_out(lstop),
    .parity_enable_out(pen), .parity_mode_out(pmode), .fifo_enable_out(fen),
    .rx_fifo_reset_out(rx_rst), .tx_fifo_reset_out(tx_rst), .divisor_out(div));

  axi_host_model u_axi_host_model (.clk_in(clk_in), .awaddr_out(awaddr),
    .awvalid_out(awvalid), .awready_in(awready), .wdata_out(wdata), .wstrb_out(wstrb),
    .wvalid_out(wvalid), .wready_in(wready), .bresp_in(bresp), .bvalid_in(bvalid),
    .bready_out(bready), .araddr_out(araddr), .arvalid_out(arvalid),
    .arready_in(arready), .rdata_in(rdata), .rresp_in(rresp), .rvalid_in(rvalid),
    .rready_out(rready));

  task check(input [31:0] seen, input [31:0] exp);
    begin
      n_compared = n_compared + 1;
      if (seen !== exp)
      begin
        $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        n_fail = n_fail + 1;
      end
    end
  endtask
  task wait_n(input integer n);
    repeat (n) @(posedge clk_in);
  endtask
  task wr_chk(input [7:0] a, input [31:0] d, input [1:0] er);
    begin
      u_axi_host_model.wr(a, d, rs);
      check(rs, er);
    end
  endtask
  task rd_chk(input [7:0] a, input [31:0] exp);
    begin
      wait_n(2);
      u_axi_host_model.rd(a, rd_d, rs);
      check(rd_d, exp);
      check(rs, 2'h0);
    end
  endtask
  task t_reset;
    begin
      rd_chk(8'h00, 32'h01);
      rd_chk(8'h04, 32'h00);
      check(irq, 1'b0);
      check({pmode, pen, lstop, wlen, fen}, 7'h00);
    end
  endtask
  task t_prio;
    begin
      wr_chk(8'h08, 32'h3F, 2'h0);
      wr_chk(8'h04, 32'h80, 2'h0);
      wr_chk(8'h0C, 32'h10, 2'h0);
      wr_chk(8'h04, 32'h00, 2'h0);
      lv <= 5'h1F;
      xoff <= 1'b1;
      cts <= 1'b1;
      @(posedge clk_in);
      xoff <= 1'b0;
      cts <= 1'b0;
      for (k = 0; k < 6; k = k + 1)
      begin
        rd_chk(8'h00, ID_SEQ[47 - 8 * k -: 8]);
        if (k < 5) lv[k] <= 1'b0;
      end
      check(irq, 1'b1);
      rd_chk(8'h00, 32'h10);
      xon <= 1'b1;
      @(posedge clk_in);
      xon <= 1'b0;
      rd_chk(8'h00, 32'h20);
      rd_chk(8'h00, 32'h01);
      lv[0] <= 1'b1;
      wr_chk(8'h08, 32'h3B, 2'h0);
      rd_chk(8'h00, 32'h01);
      wr_chk(8'h08, 32'h3F, 2'h0);
      rd_chk(8'h00, 32'h06);
      lv <= 5'h00;
      wr_chk(8'h04, 32'h80, 2'h0);
      wr_chk(8'h0C, 32'h00, 2'h0);
      wr_chk(8'h04, 32'h00, 2'h0);
      cts <= 1'b1;
      @(posedge clk_in);
      cts <= 1'b0;
      rd_chk(8'h00, 32'h01);
      wr_chk(8'h10, 32'h03, 2'h0);
      rd_chk(8'h00, 32'hC1);
      check(fen, 1'b1);
      check(fr_seen, 2'h1);
      wr_chk(8'h10, 32'h05, 2'h0);
      rd_chk(8'h10, 32'h01);
      check(fr_seen, 2'h3);
    end
  endtask
  task t_format;
    begin
      for (k = 0; k < 4; k = k + 1)
      begin
        v = {2'b00, k[1:0], 1'b1, k[0], k[1:0]};
        wr_chk(8'h04, {24'h0, v}, 2'h0);
        rd_chk(8'h04, {24'h0, v});
        check({pmode, pen, lstop, wlen}, {k[1:0], 1'b1, k[0], k[1:0]});
      end
      txs <= 1'b1;
      wr_chk(8'h04, 32'h40, 2'h0);
      rd_chk(8'h04, 32'h40);
      check(tx_line, 1'b0);
      check(pen, 1'b0);
      wr_chk(8'h04, 32'h00, 2'h0);
      rd_chk(8'h04, 32'h00);
      check(tx_line, 1'b1);
    end
  endtask
  task t_latch;
    begin
      wr_chk(8'h14, 32'h1234, 2'h2);
      wr_chk(8'h20, 32'h0, 2'h2);
      wr_chk(8'h04, 32'h80, 2'h0);
      wr_chk(8'h14, 32'h1234, 2'h0);
      rd_chk(8'h14, 32'h1234);
      check(div, 16'h1234);
      wr_chk(8'h04, 32'h00, 2'h0);
      u_axi_host_model.rd(8'h14, rd_d, rs);
      check(rs, 2'h2);
      check(rd_d, 32'h0);
    end
  endtask
  task wrap_up;
    begin
      $display("compared %0d failed %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0)
        $display("SIMULATION PASSED");
      else
        $display("SIMULATION FAILED");
      $finish;
    end
  endtask

  initial
  begin
    {clk_in, reset_n_in, xoff, xon, cts, txs, lv} = 11'h000;
    n_fail = 0;
    n_compared = 0;
    repeat (2) @(posedge clk_in);
    reset_n_in <= 1'b1;
    t_reset;
    t_prio;
    t_format;
    t_latch;
    wrap_up;
  end
  // Whole run takes well under a thousand cycles
  initial
  begin
    #40000;
    n_fail = n_fail + 1;
    wrap_up;
  end
endmodule

// ===== testbench/uart_irq_format_asserts.sv
/*
  Checker for the UART interrupt and line format block.
  Assumes a bind onto uart_irq_format: one clock, asynchronous active-low reset.
*/
`timescale 1ns/1ps
module uart_irq_format_asserts (
  input wire clk_in,
  input wire reset_n_in,
  input wire s_axi_awvalid_in,
  input wire s_axi_awready_out,
  input wire s_axi_wvalid_in,
  input wire s_axi_wready_out,
  input wire s_axi_bvalid_out,
  input wire s_axi_bready_in,
  input wire s_axi_arvalid_in,
  input wire s_axi_arready_out,
  input wire [31:0] s_axi_rdata_out,
  input wire s_axi_rvalid_out,
  input wire s_axi_rready_in,
  input wire tx_serial_in,
  input wire tx_line_out,
  input wire [1:0] word_len_out,
  input wire long_stop_out,
  input wire [1:0] parity_mode_out,
  input wire rx_fifo_reset_out
);
  reg bv_d_r;
  wire wr_seen;
  // Word length, stop and parity outputs may only move just after a write response
  assign wr_seen = s_axi_bvalid_out || bv_d_r;
  always @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      bv_d_r <= 1'b0;
    else
      bv_d_r <= s_axi_bvalid_out;
  end
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);
  b_hold_a: assert property (s_axi_bvalid_out && !s_axi_bready_in |=> s_axi_bvalid_out)
    else $error("write response dropped");
  r_hold_a: assert property (s_axi_rvalid_out && !s_axi_rready_in
    |=> s_axi_rvalid_out && $stable(s_axi_rdata_out)) else $error("read data not held");
  rd_lat_a: assert property (s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out)
    else $error("read answer late");
  wr_lat_a: assert property (s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in
    && s_axi_wready_out |-> ##[1:2] s_axi_bvalid_out) else $error("write answer late");
  ar_block_a: assert property (s_axi_rvalid_out |-> !s_axi_arready_out)
    else $error("address taken during read answer");
  tx_rise_a: assert property ($rose(tx_line_out) |-> $past(tx_serial_in))
    else $error("transmit line rose without data");
  wlen_move_a: assert property ($changed(word_len_out) |-> $past(wr_seen))
    else $error("word length moved without write");
  stop_move_a: assert property ($changed(long_stop_out) |-> $past(wr_seen))
    else $error("stop length moved without write");
  par_move_a: assert property ($changed(parity_mode_out) |-> $past(wr_seen))
    else $error("parity moved without write");
  rx_pulse_a: assert property (rx_fifo_reset_out |=> !rx_fifo_reset_out)
    else $error("fifo reset longer than one cycle");
endmodule

bind uart_irq_format uart_irq_format_asserts u_chk (
  .clk_in(clk_in),
  .reset_n_in(reset_n_in),
  .s_axi_awvalid_in(s_axi_awvalid_in),
  .s_axi_awready_out(s_axi_awready_out),
  .s_axi_wvalid_in(s_axi_wvalid_in),
  .s_axi_wready_out(s_axi_wready_out),
  .s_axi_bvalid_out(s_axi_bvalid_out),
  .s_axi_bready_in(s_axi_bready_in),
  .s_axi_arvalid_in(s_axi_arvalid_in),
  .s_axi_arready_out(s_axi_arready_out),
  .s_axi_rdata_out(s_axi_rdata_out),
  .s_axi_rvalid_out(s_axi_rvalid_out),
  .s_axi_rready_in(s_axi_rready_in),
  .tx_serial_in(tx_serial_in),
  .tx_line_out(tx_line_out),
  .word_len_out(word_len_out),
  .long_stop_out(long_stop_out),
  .parity_mode_out(parity_mode_out),
  .rx_fifo_reset_out(rx_fifo_reset_out)
);
